// [rtl/amp_scale_pkg.sv]
package amp_scale_pkg;
  localparam int INTERVAL_W = 20;
  localparam int AMP_W = 8;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  // register word addresses
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_THRESHOLD = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_FEED = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_INTERVAL = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_TUNED = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h5;
  // config field positions
  localparam int CFG_AUTOSCALE = 0;
  localparam int CFG_FORCE_CURRENT = 1;
  localparam int CFG_FREEWHEEL = 2;
  localparam int CFG_TUNE_DONE = 3;
  localparam int CFG_RUN_LSB = 8;
  localparam int CFG_HOLD_LSB = 16;
  localparam int CUR_W = 5;
  localparam logic [3:0] CONFIG_RESET = 4'h1;
  localparam logic [7:0] OFFSET_RESET = 8'h24;
  localparam logic [7:0] GRAD_RESET = 8'h14;
  localparam logic [7:0] AMP_MAX = 8'hFF;
  localparam logic [7:0] SINE_PEAK = 8'hF8;
  localparam int STEP_SCALE = 256;
  localparam logic [4:0] CUR_LIMIT_LOW = 5'h08;
  localparam logic [4:0] CUR_FULL = 5'h1F;
  localparam logic [19:0] INTERVAL_MAX = 20'hFFFFF;
endpackage : amp_scale_pkg

// [rtl/step_interval_meter.sv]
`timescale 1ns/1ps
module step_interval_meter #(
  parameter int W = 20
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // step pulse in
  input wire logic step_pulse,
  // measurement out
  output logic [W-1:0] interval_r,
  output logic valid_r
);
  logic [W-1:0] count_r;

  // counter saturates so a stopped motor reads as the slowest velocity
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else if (step_pulse) begin
      // counting from one makes the reading the full spacing between two steps
      count_r <= {{(W-1){1'b0}}, 1'b1}; // R2
    end else if (count_r != {W{1'b1}}) begin
      count_r <= count_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      interval_r <= {W{1'b1}};
      valid_r <= 1'b0;
    end else begin
      valid_r <= step_pulse;
      if (step_pulse || count_r == {W{1'b1}}) begin
        interval_r <= count_r;
      end
    end
  end
endmodule : step_interval_meter

// [rtl/amp_scale_top.sv]
// Operation
// R1 - amplitude is offset plus gradient times step rate
// R2 - velocity comes from measured step interval
// R3 - pure velocity scaling only via cleared select bit
// R4 - amplitude eight bits, sine peak 248
// R5 - threshold selects quiet or current chopper
// R6 - step interval measurement is readable
// R7 - zero threshold keeps quiet chopper always
// R8 - hold regulation value across handover
// R9 - threshold default loaded from OTP
// R10 - host starts quiet chopper at standstill
// R11 - host waits 128 chopper periods
// R12 - host keeps run current 8 to 31
// R13 - reduced currents from tuned or programmed values
// R14 - tuned offset and gradient are readable
// R15 - low currents accepted after tuning completes
// R16 - host keeps run current above limit
// R17 - freewheel lets current reach zero
// R18 - host clears flags, restarts from zero
// R19 - quiet chopper off below threshold
// R20 - current chopper is config XOR pin
// R21 - total amplitude saturates at 255
// R22 - interval at or above threshold stays quiet
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
module amp_scale_top
  import amp_scale_pkg::*;
#(
  parameter int CLK_HZ = 100_000_000
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port
  input wire logic [amp_scale_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [amp_scale_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [amp_scale_pkg::DATA_W-1:0] reg_rdata,
  // one-time-programmable default
  input wire logic otp_valid,
  input wire logic [amp_scale_pkg::INTERVAL_W-1:0] otp_threshold,
  // motion and pins
  input wire logic step_pulse,
  input wire logic chopper_select_pin,
  input wire logic at_standstill,
  // tuning regulator results
  input wire logic tune_update,
  input wire logic [7:0] tuned_offset_in,
  input wire logic [7:0] tuned_gradient_in,
  input wire logic [7:0] regulation_in,
  // outputs to power stage
  output logic quiet_active_r,
  output logic [amp_scale_pkg::AMP_W-1:0] total_pwm_amplitude,
  output logic [amp_scale_pkg::AMP_W-1:0] sine_amplitude,
  output logic [amp_scale_pkg::AMP_W-1:0] held_regulation,
  output logic [amp_scale_pkg::CUR_W-1:0] applied_current
);
  import amp_scale_pkg::*;

  typedef enum logic [1:0] {QUIET, CURRENT_MODE} chop_type;

  chop_type chop_r;
  logic [INTERVAL_W-1:0] step_interval_measure;
  logic interval_valid;
  logic [INTERVAL_W-1:0] velocity_switch_threshold_r;
  logic threshold_written_r;
  logic autoscale_r;
  logic force_current_r;
  logic freewheel_r;
  logic tune_done_r;
  logic [CUR_W-1:0] run_current_level_r;
  logic [CUR_W-1:0] hold_current_level_r;
  logic [7:0] amplitude_offset_setting_r;
  logic [7:0] amplitude_gradient_setting_r;
  logic [7:0] tuned_offset_value_r;
  logic [7:0] tuned_gradient_value_r;
  logic [7:0] held_reg_r;
  logic [7:0] amp_r;
  logic [7:0] sine_r;
  logic [CUR_W-1:0] cur_r;
  logic [DATA_W-1:0] rdata_r;
  logic [7:0] sum_nxt;
  logic quiet_nxt;
  logic current_sel;
  logic [CUR_W-1:0] want_cur;

  // gradient * 256 * fstep/fclk with fstep = fclk/interval
  function automatic logic [7:0] scale_sum(input logic [7:0] ofs, input logic [7:0] grad,
                                           input logic [INTERVAL_W-1:0] ivl);
    logic [31:0] term;
    logic [32:0] total;
    term = 32'h0;
    total = 33'h0;
    if (ivl != '0) begin
      term = (32'(grad) * 32'(STEP_SCALE)) / 32'(ivl); // R1 R2
    end
    total = 33'(ofs) + 33'(term);
    if (total > 33'(AMP_MAX)) begin
      scale_sum = AMP_MAX; // R21
    end else begin
      scale_sum = total[7:0];
    end
  endfunction : scale_sum

  step_interval_meter #(.W(INTERVAL_W)) meter (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .step_pulse(step_pulse),
    .interval_r(step_interval_measure),
    .valid_r(interval_valid)
  );

  // register writes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      autoscale_r <= CONFIG_RESET[CFG_AUTOSCALE];
      force_current_r <= CONFIG_RESET[CFG_FORCE_CURRENT];
      freewheel_r <= CONFIG_RESET[CFG_FREEWHEEL];
      run_current_level_r <= CUR_FULL;
      hold_current_level_r <= CUR_LIMIT_LOW;
      amplitude_offset_setting_r <= OFFSET_RESET;
      amplitude_gradient_setting_r <= GRAD_RESET;
    end else if (reg_write) begin
      if (reg_addr == ADDR_CONFIG) begin
        autoscale_r <= reg_wdata[CFG_AUTOSCALE]; // R3
        force_current_r <= reg_wdata[CFG_FORCE_CURRENT];
        freewheel_r <= reg_wdata[CFG_FREEWHEEL];
        run_current_level_r <= reg_wdata[CFG_RUN_LSB +: CUR_W];
        hold_current_level_r <= reg_wdata[CFG_HOLD_LSB +: CUR_W];
      end else if (reg_addr == ADDR_FEED) begin
        amplitude_offset_setting_r <= reg_wdata[7:0];
        amplitude_gradient_setting_r <= reg_wdata[15:8];
      end
    end
  end

  // otp default applies until software writes the threshold
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      velocity_switch_threshold_r <= '0;
      threshold_written_r <= 1'b0;
    end else if (reg_write && reg_addr == ADDR_THRESHOLD) begin
      velocity_switch_threshold_r <= reg_wdata[INTERVAL_W-1:0];
      threshold_written_r <= 1'b1;
    end else if (otp_valid && !threshold_written_r) begin
      velocity_switch_threshold_r <= otp_threshold; // R9
    end
  end

  // tuning results; tune_update sets done, which only reset clears
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tuned_offset_value_r <= OFFSET_RESET;
      tuned_gradient_value_r <= GRAD_RESET;
      tune_done_r <= 1'b0;
    end else if (tune_update) begin
      tuned_offset_value_r <= tuned_offset_in;
      tuned_gradient_value_r <= tuned_gradient_in;
      tune_done_r <= 1'b1;
    end
  end

  // mode selection
  always_comb begin
    current_sel = force_current_r ^ chopper_select_pin; // R20
    quiet_nxt = !current_sel;
    if (velocity_switch_threshold_r != '0 &&
        step_interval_measure < velocity_switch_threshold_r) begin // R19 R22 R7
      quiet_nxt = 1'b0; // R5
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      chop_r <= QUIET;
    end else begin
      chop_r <= quiet_nxt ? QUIET : CURRENT_MODE;
    end
  end

  // regulation value frozen outside quiet mode, overwritten from regulation_in on re-entry while autoscale_r is set
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      held_reg_r <= '0;
    end else if (chop_r == QUIET && autoscale_r) begin
      held_reg_r <= regulation_in; // R8
    end
  end

  // amplitude: programmed values in feed-forward, tuned values otherwise
  always_comb begin
    if (autoscale_r) begin
      sum_nxt = scale_sum(tuned_offset_value_r, tuned_gradient_value_r, step_interval_measure); // R13
    end else begin
      sum_nxt = scale_sum(amplitude_offset_setting_r, amplitude_gradient_setting_r,
                          step_interval_measure); // R1 R13
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      amp_r <= '0;
      sine_r <= '0;
    end else begin
      amp_r <= sum_nxt; // R4
      sine_r <= 8'((16'(sum_nxt) * 16'(SINE_PEAK)) >> 8); // R4
    end
  end

  // current level applied to the regulator
  always_comb begin
    want_cur = at_standstill ? hold_current_level_r : run_current_level_r;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_r <= '0;
    end else begin
      if (want_cur == '0 && freewheel_r) begin
        cur_r <= '0; // R17
      end else if (want_cur < CUR_LIMIT_LOW && !tune_done_r && autoscale_r) begin
        cur_r <= CUR_LIMIT_LOW; // R15
      end else begin
        cur_r <= want_cur; // R15
      end
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else if (reg_read) begin
      if (reg_addr == ADDR_CONFIG) begin
        rdata_r <= {11'h0, hold_current_level_r, 3'h0, run_current_level_r, 4'h0,
                    tune_done_r, freewheel_r, force_current_r, autoscale_r};
      end else if (reg_addr == ADDR_THRESHOLD) begin
        rdata_r <= {12'h0, velocity_switch_threshold_r};
      end else if (reg_addr == ADDR_FEED) begin
        rdata_r <= {16'h0, amplitude_gradient_setting_r, amplitude_offset_setting_r};
      end else if (reg_addr == ADDR_INTERVAL) begin
        rdata_r <= {12'h0, step_interval_measure}; // R6
      end else if (reg_addr == ADDR_TUNED) begin
        rdata_r <= {16'h0, tuned_gradient_value_r, tuned_offset_value_r}; // R14
      end else if (reg_addr == ADDR_STATUS) begin
        rdata_r <= {15'h0, (chop_r == QUIET), held_reg_r, amp_r};
      end else begin
        rdata_r <= '0;
      end
    end else begin
      rdata_r <= '0;
    end
  end

  assign reg_rdata = rdata_r;
  assign quiet_active_r = (chop_r == QUIET);
  assign total_pwm_amplitude = amp_r;
  assign sine_amplitude = sine_r;
  assign held_regulation = held_reg_r;
  assign applied_current = cur_r;

  // the frozen value holds after the handover; regulation_in replaces it when the quiet chopper comes back with autoscale_r set
  sequence s_leave_quiet;
    chop_r == QUIET ##1 chop_r == CURRENT_MODE;
  endsequence

  sequence s_step_pair;
    step_pulse ##1 step_pulse;
  endsequence

  chk_zero_threshold_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
    (velocity_switch_threshold_r == '0 && !current_sel) |=> quiet_active_r)
    else $error("zero threshold left quiet mode");
  chk_below_threshold_off: assert property (@(posedge ref_clk) disable iff (!rst_n) // R19
    (velocity_switch_threshold_r != '0 && step_interval_measure < velocity_switch_threshold_r)
    |=> !quiet_active_r)
    else $error("quiet mode kept below threshold");
  chk_at_threshold_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n) // R22
    (step_interval_measure >= velocity_switch_threshold_r && !current_sel) |=> quiet_active_r)
    else $error("quiet mode dropped at or above threshold");
  chk_xor_select: assert property (@(posedge ref_clk) disable iff (!rst_n) // R20
    (force_current_r ^ chopper_select_pin) |=> !quiet_active_r)
    else $error("current chopper selection ignored");
  chk_hold_regulation: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
    s_leave_quiet |=> $stable(held_reg_r))
    else $error("held regulation changed after handover");
  chk_held_tracks: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
    (quiet_active_r && autoscale_r) |=> held_reg_r == $past(regulation_in))
    else $error("held regulation not tracking in quiet mode");
  chk_held_frozen: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
    !quiet_active_r |=> $stable(held_reg_r))
    else $error("held regulation moved outside quiet mode");
  chk_sum_saturate: assert property (@(posedge ref_clk) disable iff (!rst_n) // R21
    (step_interval_measure == 20'h00001 && !autoscale_r && amplitude_gradient_setting_r != 8'h0)
    |=> amp_r == AMP_MAX)
    else $error("amplitude did not saturate");
  chk_sine_peak: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
    amp_r == AMP_MAX |-> sine_r == 8'hF7)
    else $error("sine peak wrong");
  chk_freewheel_zero: assert property (@(posedge ref_clk) disable iff (!rst_n) // R17
    (freewheel_r && at_standstill && hold_current_level_r == '0) |=> cur_r == '0)
    else $error("freewheel current not zero");
  chk_low_clamp: assert property (@(posedge ref_clk) disable iff (!rst_n) // R15
    (autoscale_r && !tune_done_r && !freewheel_r && at_standstill && hold_current_level_r < CUR_LIMIT_LOW)
    |=> cur_r == CUR_LIMIT_LOW)
    else $error("current below lower limit before tuning");
  chk_low_accept: assert property (@(posedge ref_clk) disable iff (!rst_n) // R15
    (tune_done_r && at_standstill && hold_current_level_r != '0)
    |=> cur_r == $past(hold_current_level_r))
    else $error("hold level not applied after tuning");
  chk_interval_read: assert property (@(posedge ref_clk) disable iff (!rst_n) // R6
    (reg_read && reg_addr == ADDR_INTERVAL) |=> rdata_r[INTERVAL_W-1:0] == $past(step_interval_measure))
    else $error("interval read mismatch");
  chk_read_idle: assert property (@(posedge ref_clk) disable iff (!rst_n) // R6
    !reg_read |=> rdata_r == '0)
    else $error("read data not cleared after read cycle");
  chk_config_read: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
    (reg_read && reg_addr == ADDR_CONFIG) |=> rdata_r[CFG_AUTOSCALE] == $past(autoscale_r))
    else $error("scaling select read mismatch");
  chk_tuned_read: assert property (@(posedge ref_clk) disable iff (!rst_n) // R14
    (reg_read && reg_addr == ADDR_TUNED)
    |=> rdata_r == {16'h0, $past(tuned_gradient_value_r), $past(tuned_offset_value_r)})
    else $error("tuned values read mismatch");
  chk_tuned_latch: assert property (@(posedge ref_clk) disable iff (!rst_n) // R14
    tune_update |=> (tuned_offset_value_r == $past(tuned_offset_in) &&
                     tuned_gradient_value_r == $past(tuned_gradient_in) && tune_done_r))
    else $error("tuned values not latched");
  chk_otp_default: assert property (@(posedge ref_clk) disable iff (!rst_n) // R9
    (otp_valid && !threshold_written_r && !(reg_write && reg_addr == ADDR_THRESHOLD))
    |=> velocity_switch_threshold_r == $past(otp_threshold))
    else $error("default threshold not loaded");
  chk_threshold_write: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
    (reg_write && reg_addr == ADDR_THRESHOLD)
    |=> velocity_switch_threshold_r == $past(reg_wdata[INTERVAL_W-1:0]))
    else $error("threshold write lost");
  chk_step_valid: assert property (@(posedge ref_clk) disable iff (!rst_n) // R2
    step_pulse |=> interval_valid)
    else $error("interval not marked after step");
  chk_step_pair: assert property (@(posedge ref_clk) disable iff (!rst_n) // R2
    s_step_pair |=> step_interval_measure == 20'h00001)
    else $error("back to back steps not measured as one cycle");
  chk_feed_offset: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1 R3
    (!autoscale_r && amplitude_gradient_setting_r == 8'h0)
    |=> amp_r == $past(amplitude_offset_setting_r))
    else $error("feed-forward offset not used");
endmodule : amp_scale_top

// [dv/regulation_model.sv]
`timescale 1ns/1ps
module regulation_model #(
  parameter int PER = 64
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // live regulator value towards the block
  output logic [7:0] regulation_in
);
  int cnt_r;
  // the regulator settles once per chopper period, so its value steps and never stands still for long
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 0;
      regulation_in <= 8'h40;
    end else begin
      cnt_r <= (cnt_r == PER - 1) ? 0 : cnt_r + 1;
      if (cnt_r == PER - 1) begin
        regulation_in <= regulation_in + 8'h25;
      end
    end
  end
endmodule : regulation_model

// [dv/tb.sv]
`timescale 1ns/1ps
module tb;
  import amp_scale_pkg::*;
  logic ref_clk, rst_n, reg_write, reg_read, otp_valid, step_pulse, chopper_select_pin, at_standstill, tune_update;
  logic quiet_active_r;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, d;
  logic [INTERVAL_W-1:0] otp_threshold;
  logic [7:0] tuned_offset_in, tuned_gradient_in, regulation_in, held_regulation, o, g, hv, rnd;
  logic [AMP_W-1:0] total_pwm_amplitude, sine_amplitude;
  logic [CUR_W-1:0] applied_current;
  int fail_count, tests_run, cycles, per, scnt, iv;
  localparam int CHOP_PER = 64;
  amp_scale_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .otp_valid(otp_valid),
    .otp_threshold(otp_threshold), .step_pulse(step_pulse), .chopper_select_pin(chopper_select_pin),
    .at_standstill(at_standstill), .tune_update(tune_update), .tuned_offset_in(tuned_offset_in),
    .tuned_gradient_in(tuned_gradient_in), .regulation_in(regulation_in), .quiet_active_r(quiet_active_r),
    .total_pwm_amplitude(total_pwm_amplitude), .sine_amplitude(sine_amplitude),
    .held_regulation(held_regulation), .applied_current(applied_current));
  regulation_model #(.PER(CHOP_PER)) partner (.ref_clk(ref_clk), .rst_n(rst_n), .regulation_in(regulation_in));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr
  function automatic int amp_exp(input int ofs, input int grd, input int ivl);
    int s;
    s = ofs + grd * STEP_SCALE / ivl;
    return (s > 255) ? 255 : s;
  endfunction : amp_exp
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("mismatches %0d, comparisons %0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic amp_chk(input int ofs, input int grd);
    int e;
    e = amp_exp(ofs, grd, per);
    chk(32'(total_pwm_amplitude), 32'(e));
    chk(32'(sine_amplitude), 32'(e * 248 / 256));
  endtask : amp_chk
  always @(posedge ref_clk) begin
    step_pulse <= (per != 0 && scnt == 0);
    scnt <= (scnt + 1 >= per) ? 0 : scnt + 1;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict;
    end
  end
  initial begin
    {rst_n, reg_write, reg_read, chopper_select_pin, tune_update} = '0;
    {reg_addr, reg_wdata, tuned_offset_in, tuned_gradient_in} = '0;
    otp_valid = 1'b1;
    otp_threshold = 20'h00400;
    at_standstill = 1'b1;
    {per, fail_count, tests_run} = '0;
    rnd = 8'h2C;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    cyc(3);
    rd(ADDR_CONFIG);
    chk(d, 32'h00081F01);
    rd(ADDR_FEED);
    chk(d, 32'h00001424);
    rd(ADDR_THRESHOLD);
    chk(d, 32'h00000400);
    rd(4'h7);
    chk(d, 32'h0);
    wr(ADDR_TUNED, 32'h0000FFFF);
    rd(ADDR_TUNED);
    chk(d, 32'h00001424);
    chk(32'(quiet_active_r), 32'h1);
    wr(ADDR_CONFIG, 32'h00031401);
    cyc(3);
    chk(32'(applied_current), 32'h08);
    @(posedge ref_clk) at_standstill <= 1'b0;
    cyc(3);
    chk(32'(applied_current), 32'h14);
    o = lfsr(rnd);
    g = lfsr(o);
    rnd = g;
    @(posedge ref_clk);
    tuned_offset_in <= o >> 1;
    tuned_gradient_in <= g;
    tune_update <= 1'b1;
    @(posedge ref_clk) tune_update <= 1'b0;
    o = o >> 1;
    rd(ADDR_TUNED);
    chk(d, {16'h0, g, o});
    rd(ADDR_CONFIG);
    chk(32'(d[CFG_TUNE_DONE]), 32'h1);
    @(posedge ref_clk) at_standstill <= 1'b1;
    cyc(3);
    chk(32'(applied_current), 32'h03);
    wr(ADDR_CONFIG, 32'h00001405);
    cyc(3);
    chk(32'(applied_current), 32'h0);
    // motion starts only now, from standstill, once standstill regulation has had its time
    cyc(128 * CHOP_PER);
    @(posedge ref_clk) at_standstill <= 1'b0;
    per <= 1000;
    cyc(3500);
    chk(32'(quiet_active_r), 32'h0);
    rd(ADDR_INTERVAL);
    iv = int'(d);
    chk(d, 32'(per));
    amp_chk(o, g);
    wr(ADDR_THRESHOLD, 32'h0);
    cyc(3);
    chk(32'(quiet_active_r), 32'h1);
    wr(ADDR_CONFIG, 32'h00001400);
    for (int i = 0; i < 4; i++) begin
      o = lfsr(rnd) >> 1;
      g = lfsr(o);
      rnd = g;
      if (i == 3) {o, g} = 16'hFAFF;
      if (i == 2) g = 8'h00;
      wr(ADDR_FEED, {16'h0, g, o});
      cyc(3);
      amp_chk(o, g);
    end
    @(posedge ref_clk) per <= 1;
    cyc(8);
    amp_chk(o, g);
    @(posedge ref_clk) per <= 1000;
    cyc(1100);
    wr(ADDR_CONFIG, 32'h00001401);
    wr(ADDR_THRESHOLD, 32'(iv));
    cyc(3);
    chk(32'(quiet_active_r), 32'h1);
    @(regulation_in);
    cyc(4);
    chk(32'(held_regulation), 32'(regulation_in));
    wr(ADDR_THRESHOLD, 32'(iv + 1));
    cyc(3);
    chk(32'(quiet_active_r), 32'h0);
    hv = held_regulation;
    cyc(150);
    chk(32'(held_regulation), 32'(hv));
    rd(ADDR_STATUS);
    chk({d[16], d[15:8]}, {23'h0, 1'b0, hv});
    wr(ADDR_THRESHOLD, 32'h0);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CONFIG, 32'h00001400 | 32'(k[0]) << CFG_FORCE_CURRENT);
      @(posedge ref_clk) chopper_select_pin <= k[1];
      cyc(3);
      chk(32'(quiet_active_r), 32'(!(k[0] ^ k[1])));
    end
    give_verdict;
  end
endmodule : tb
